//--- rtl/xcvr_pkg.sv
package xcvr_pkg;
   localparam int          DATA_W       = 18;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          ADDR_W       = 4;
   localparam logic [3:0]  CTRL_ADDR    = 4'h0;
   localparam logic [3:0]  STAT_ADDR    = 4'h4;
   localparam logic [3:0]  LOG_ADDR     = 4'h8;
   localparam logic [3:0]  HELD_ADDR    = 4'hC;
   localparam int          CTRL_LOG_EN  = 0;
   localparam logic        LOG_EN_RST   = 1'b0;
   localparam int          STAT_OVF     = 0;
   localparam int          STAT_EMPTY   = 1;
   localparam int          STAT_FULL    = 2;
   localparam int          STAT_AB_TR   = 3;
   localparam int          STAT_BA_TR   = 4;
   localparam int          STAT_AB_OE   = 5;
   localparam int          STAT_BA_OE   = 6;
   localparam int          STAT_LVL_LSB = 8;
   localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

   typedef struct packed {
      logic oe;
      logic le;
      logic clk;
   } lane_ctl_t;
endpackage : xcvr_pkg

//--- rtl/bus_transceiver.sv
`timescale 1ns/1ps

module xfer_lane #(
   parameter int W      = xcvr_pkg::DATA_W,
   parameter bit OE_LOW = 1'b0
) (
   input  wire logic                sys_clk,     // system clock
   input  wire logic                resetn,      // async reset, low
   input  wire logic [W-1:0]        src_in,      // source port pins
   input  wire xcvr_pkg::lane_ctl_t ctl_in,      // raw control pins
   output logic      [W-1:0]        dst_out,     // driven port level
   output logic                     dst_oe_n,    // low while driving
   output logic      [W-1:0]        held,        // storage content
   output logic                     transparent, // latch enable seen
   output logic                     oe_seen,     // output enable seen
   output logic                     capture      // clock edge capture
);
   import xcvr_pkg::*;
   localparam int            SW  = W + 3;
   localparam logic [SW-1:0] RST = {OE_LOW, 1'b0, 1'b1, {W{1'b0}}};

   logic [SW-1:0] s1_q, s2_q, s3_q, st_q, st_d;
   logic [W-1:0]  q_q, q_d, d_st;
   logic          le_st, clk_st, oe_st, rise;
   logic          clk_prev_q, oe_n_q, oe_n_d, cap_q, cap_d;

   assign oe_st  = st_q[W+2] ^ OE_LOW;
   assign le_st  = st_q[W+1];
   assign clk_st = st_q[W];
   assign d_st   = st_q[W-1:0];
   assign rise   = clk_st & ~clk_prev_q;

   // a change counts once second and third stages agree
   always_comb begin
      for (int i = 0; i < SW; i++) begin
         st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
      end
   end

   always_comb begin
      q_d    = q_q;
      cap_d  = 1'b0;
      oe_n_d = ~oe_st;
      if (le_st) begin
         q_d = d_st;
      end else if (rise) begin
         q_d   = d_st;
         cap_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s1_q       <= RST;
         s2_q       <= RST;
         s3_q       <= RST;
         st_q       <= RST;
         clk_prev_q <= 1'b1;   // idle-high clock: no edge at reset exit
         q_q        <= '0;
         oe_n_q     <= 1'b1;
         cap_q      <= 1'b0;
      end else begin
         s1_q       <= {ctl_in, src_in};
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         st_q       <= st_d;
         clk_prev_q <= clk_st;
         q_q        <= q_d;
         oe_n_q     <= oe_n_d;
         cap_q      <= cap_d;
      end
   end

   assign dst_out     = q_q;
   assign dst_oe_n    = oe_n_q;
   assign held        = q_q;
   assign transparent = le_st;
   assign oe_seen     = oe_st;
   assign capture     = cap_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_transp;
      le_st |=> q_q == $past(d_st);
   endproperty
   a_transp: assert property (p_transp)
      else $error("transparent data not passed");
   property p_hold;
      !le_st && !rise |=> q_q == $past(q_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held data changed without edge");
   property p_edge;
      !le_st && rise |=> capture && q_q == $past(d_st);
   endproperty
   a_edge: assert property (p_edge)
      else $error("rising edge did not capture");
   property p_drive;
      oe_st |=> !dst_oe_n;
   endproperty
   a_drive: assert property (p_drive)
      else $error("enabled port not driven");
   property p_hiz;
      !oe_st |=> dst_oe_n;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("disabled port still driven");
   property p_fall;
      $fell(le_st) && !rise |=> q_q == $past(d_st, 2);
   endproperty
   a_fall: assert property (p_fall)
      else $error("level lost when latch enable fell");
   c_fall: cover property (le_st ##1 !le_st ##1 !le_st);
   c_edge: cover property (!le_st && rise ##1 capture);
   c_oe:   cover property (!dst_oe_n ##1 dst_oe_n);
endmodule : xfer_lane

module sfifo #(
   parameter int W     = xcvr_pkg::DATA_W,
   parameter int DEPTH = xcvr_pkg::FIFO_DEPTH
) (
   input  wire logic                     sys_clk,   // system clock
   input  wire logic                     resetn,    // async reset, low
   input  wire logic                     in_valid,  // write request
   output logic                          in_ready,  // room for a word
   input  wire logic [W-1:0]             in_data,   // write data
   output logic                          out_valid, // word available
   input  wire logic                     out_ready, // pop request
   output logic      [W-1:0]             out_data,  // head word
   output logic      [$clog2(DEPTH):0]   level      // words held
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
   logic         push, pop;

   assign level     = wp_q - rp_q;
   assign in_ready  = level != (AW+1)'(DEPTH);
   assign out_valid = wp_q != rp_q;
   assign out_data  = mem[rp_q[AW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end
endmodule : sfifo

// How it works
// - a-to-b latch enable high passes port a straight to port b.
// - latch enable low and clock steady keeps the stored a data.
// - latch enable low, rising a-to-b clock stores current a data.
// - a-to-b output enable high drives port b with stored data.
// - a-to-b output enable low floats port b regardless of all else.
// - b-to-a direction behaves alike with its own three controls.
// - a-to-b enable is active high, b-to-a enable active low.
// - latch enable falling with clock steady holds the prior level.
// - eighteen bits per direction share one set of controls.
module bus_transceiver #(
   parameter int W     = xcvr_pkg::DATA_W,
   parameter int DEPTH = xcvr_pkg::FIFO_DEPTH
) (
   input  wire logic                    sys_clk,           // 100 MHz
   input  wire logic                    resetn,            // async, low
   input  wire logic [xcvr_pkg::ADDR_W-1:0] avs_address,   // byte addr
   input  wire logic                    avs_read,          // read strobe
   input  wire logic                    avs_write,         // write strobe
   input  wire logic [3:0]              avs_byteenable,    // lanes
   input  wire logic [31:0]             avs_writedata,     // write data
   output logic      [31:0]             avs_readdata,      // read data
   output logic                         avs_waitrequest,   // stall
   input  wire logic [W-1:0]            a_in,              // port a level
   output logic      [W-1:0]            a_out,             // port a drive
   output logic                         a_oe_n,            // low: drive a
   input  wire logic [W-1:0]            b_in,              // port b level
   output logic      [W-1:0]            b_out,             // port b drive
   output logic                         b_oe_n,            // low: drive b
   input  wire logic                    a_to_b_output_enable,
   input  wire logic                    b_to_a_output_enable_n,
   input  wire logic                    a_to_b_latch_enable,
   input  wire logic                    b_to_a_latch_enable,
   input  wire logic                    a_to_b_clock,      // pin clock
   input  wire logic                    b_to_a_clock       // pin clock
);
   import xcvr_pkg::*;
   localparam int LW = $clog2(DEPTH) + 1;

   logic [W-1:0]  ab_held, ba_held, pend_data_q, pend_data_d, f_out;
   logic          ab_tr, ba_tr, ab_oe, ba_oe, ab_cap;
   logic          pend_q, pend_d, f_in_ready, f_out_valid, pop;
   logic [LW-1:0] f_level;
   logic          log_en_q, log_en_d, ovf_q, ovf_d, ack_q, ack_d, req;
   logic [31:0]   rdata_q, rdata_d;

   xfer_lane #(.W(W), .OE_LOW(1'b0)) u_ab (
      .sys_clk     (sys_clk),
      .resetn      (resetn),
      .src_in      (a_in),
      .ctl_in      ({a_to_b_output_enable, a_to_b_latch_enable,
                     a_to_b_clock}),
      .dst_out     (b_out),
      .dst_oe_n    (b_oe_n),
      .held        (ab_held),
      .transparent (ab_tr),
      .oe_seen     (ab_oe),
      .capture     (ab_cap)
   );

   xfer_lane #(.W(W), .OE_LOW(1'b1)) u_ba (
      .sys_clk     (sys_clk),
      .resetn      (resetn),
      .src_in      (b_in),
      .ctl_in      ({b_to_a_output_enable_n, b_to_a_latch_enable,
                     b_to_a_clock}),
      .dst_out     (a_out),
      .dst_oe_n    (a_oe_n),
      .held        (ba_held),
      .transparent (ba_tr),
      .oe_seen     (ba_oe),
      .capture     ()
   );

   sfifo #(.W(W), .DEPTH(DEPTH)) u_log (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (pend_q),
      .in_ready  (f_in_ready),
      .in_data   (pend_data_q),
      .out_valid (f_out_valid),
      .out_ready (pop),
      .out_data  (f_out),
      .level     (f_level)
   );

   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata    = rdata_q;
   assign pop = ack_q & avs_read & (avs_address == LOG_ADDR);

   // a-to-b clocked captures queue for software; one meeting a stalled slot drops and flags
   always_comb begin
      pend_d      = pend_q & ~f_in_ready;
      pend_data_d = pend_data_q;
      ovf_d       = ovf_q;
      log_en_d    = log_en_q;
      ack_d       = req & ~ack_q;
      rdata_d     = rdata_q;
      if (ack_q && avs_write) begin
         if (avs_address == CTRL_ADDR && avs_byteenable[0]) begin
            log_en_d = avs_writedata[CTRL_LOG_EN];
         end else if (avs_address == STAT_ADDR && avs_byteenable[0]) begin
            ovf_d = ovf_q & ~avs_writedata[STAT_OVF];
         end
      end
      if (ab_cap && log_en_q) begin
         if (pend_d) begin
            ovf_d = 1'b1;
         end else begin
            pend_d      = 1'b1;
            pend_data_d = ab_held;
         end
      end
      if (req && !ack_q) begin
         rdata_d = RDATA_RST;
         if (avs_address == CTRL_ADDR) begin
            rdata_d[CTRL_LOG_EN] = log_en_q;
         end else if (avs_address == STAT_ADDR) begin
            rdata_d[STAT_OVF]   = ovf_q;
            rdata_d[STAT_EMPTY] = ~f_out_valid;
            rdata_d[STAT_FULL]  = ~f_in_ready;
            rdata_d[STAT_AB_TR] = ab_tr;
            rdata_d[STAT_BA_TR] = ba_tr;
            rdata_d[STAT_AB_OE] = ab_oe;
            rdata_d[STAT_BA_OE] = ba_oe;
            rdata_d[STAT_LVL_LSB +: LW] = f_level;
         end else if (avs_address == LOG_ADDR) begin
            rdata_d[W-1:0] = f_out_valid ? f_out : '0;
         end else if (avs_address == HELD_ADDR) begin
            rdata_d[W-1:0] = ab_held;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pend_q      <= 1'b0;
         pend_data_q <= '0;
         ovf_q       <= 1'b0;
         log_en_q    <= LOG_EN_RST;
         ack_q       <= 1'b0;
         rdata_q     <= RDATA_RST;
      end else begin
         pend_q      <= pend_d;
         pend_data_q <= pend_data_d;
         ovf_q       <= ovf_d;
         log_en_q    <= log_en_d;
         ack_q       <= ack_d;
         rdata_q     <= rdata_d;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_ab_en;
      a_to_b_output_enable [*5] |=> !b_oe_n;
   endproperty
   a_ab_en: assert property (p_ab_en)
      else $error("b port not driven with enable high");
   property p_ba_en;
      b_to_a_output_enable_n [*5] |=> a_oe_n;
   endproperty
   a_ba_en: assert property (p_ba_en)
      else $error("a port driven with enable high");
   property p_ba_flow;
      (b_to_a_latch_enable && $stable(b_in)) [*6] |=> a_out == $past(b_in);
   endproperty
   a_ba_flow: assert property (p_ba_flow)
      else $error("b data not passed to a");
   c_log: cover property (ab_cap && log_en_q ##[1:3] f_out_valid);
   c_rd:  cover property (pop);
endmodule : bus_transceiver

//--- verification/port_side.sv
`timescale 1ns/1ps

// bus logic on one port; device drive wins, a released wire keeps flipping
module port_side (
   input  wire logic [xcvr_pkg::DATA_W-1:0] dev_out,  // device drive value
   input  wire logic                        dev_oe_n, // low: device drives
   input  wire logic [xcvr_pkg::DATA_W-1:0] drv,      // bus logic value
   input  wire logic                        drv_en,   // bus logic drives
   input  wire logic                        sys_clk,  // system clock
   output logic      [xcvr_pkg::DATA_W-1:0] pin       // resolved wire level
);
   import xcvr_pkg::*;
   logic [DATA_W-1:0] float_q;

   initial float_q = '0;
   always @(posedge sys_clk) begin
      float_q <= ~pin;
   end

   always_comb begin
      if (!dev_oe_n) pin = dev_out;
      else if (drv_en) pin = drv;
      else pin = float_q;
   end
endmodule : port_side

//--- verification/bidir_latch_register_transceiver_test.sv
`timescale 1ns/1ps

module bidir_latch_register_transceiver_test;
   import xcvr_pkg::*;
   logic              sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0]       avs_writedata, avs_readdata, lfsr_q, got, want;
   logic [DATA_W-1:0] a_in, a_out, b_in, b_out, a_drv, b_drv, d, e;
   logic              a_oe_n, b_oe_n, ab_oe, ba_oe_n, ab_le, ba_le;
   logic              ab_clk, ba_clk;
   logic [1:0]        probe;
   logic [3:0]        be;
   logic [31:0]       exp_q[$];
   logic [DATA_W-1:0] log_w[18];
   int                n_fail, n_tests, i;

   bus_transceiver i_dut (
      .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(be),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .a_in(a_in), .a_out(a_out),
      .a_oe_n(a_oe_n), .b_in(b_in), .b_out(b_out), .b_oe_n(b_oe_n),
      .a_to_b_output_enable(ab_oe), .b_to_a_output_enable_n(ba_oe_n),
      .a_to_b_latch_enable(ab_le), .b_to_a_latch_enable(ba_le),
      .a_to_b_clock(ab_clk), .b_to_a_clock(ba_clk));
   port_side i_side_a (.dev_out(a_out), .dev_oe_n(a_oe_n), .drv(a_drv),
      .drv_en(ba_oe_n), .sys_clk(sys_clk), .pin(a_in));
   port_side i_side_b (.dev_out(b_out), .dev_oe_n(b_oe_n), .drv(b_drv),
      .drv_en(!ab_oe), .sys_clk(sys_clk), .pin(b_in));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic rnd(output logic [DATA_W-1:0] v);
      lfsr_q = lfsr_next(lfsr_q);
      v = lfsr_q[DATA_W-1:0];
   endtask : rnd

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // request held until an edge samples waitrequest low, released one edge later
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] adr,
                      input logic [31:0] wd);
      int k;
      @(posedge sys_clk);
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_address   <= adr;
      avs_writedata <= wd;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         n_fail++;
         conclude();
      end
      @(posedge sys_clk);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [ADDR_W-1:0] adr, input logic [31:0] x);
      exp_q.push_back(x);
      bus(1'b0, adr, 32'h0);
   endtask : rd

   task automatic pr(input logic [1:0] sel, input logic [31:0] x);
      exp_q.push_back(x);
      @(posedge sys_clk);
      probe <= sel;
      @(posedge sys_clk);
      probe <= 2'd0;
   endtask : pr

   task automatic done(input string s);
      $display("test %0s done", s);
   endtask : done

   // at the accepting edge or a probe edge, takes the oldest note
   always @(posedge sys_clk) begin
      if ((avs_read && avs_waitrequest === 1'b0) || probe != 2'd0) begin
         got = probe == 2'd1 ? {13'h0, b_oe_n, b_out} :
               probe == 2'd2 ? {13'h0, a_oe_n, a_out} : avs_readdata;
         want = 32'hFFFF_FFFF;
         if (exp_q.size() > 0) want = exp_q.pop_front();
         n_tests++;
         if (got !== want) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
         end
      end
   end

   initial begin
      lfsr_q        = 32'hEAD5_A16D;
      resetn        = 1'b0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_address   = '0;
      avs_writedata = '0;
      probe         = 2'd0;
      be            = 4'hF;
      a_drv         = '0;
      b_drv         = '0;
      ab_oe         = 1'b0;
      ba_oe_n       = 1'b1;
      ab_le         = 1'b0;
      ba_le         = 1'b0;
      ab_clk        = 1'b1;
      ba_clk        = 1'b1;
      cyc(2);
      resetn <= 1'b1;
      cyc(8);
      rd(CTRL_ADDR, RDATA_RST);
      rd(STAT_ADDR, 32'h1 << STAT_EMPTY);
      wr_unmapped: bus(1'b1, 4'h1, 32'hFFFF_FFFF);
      rd(4'h1, 32'h0);
      be <= 4'h0;
      bus(1'b1, CTRL_ADDR, 32'h1);
      be <= 4'hF;
      rd(CTRL_ADDR, RDATA_RST);
      pr(2'd1, 32'h0004_0000);
      pr(2'd2, 32'h0004_0000);
      done("reset");
      rnd(d);
      ab_oe <= 1'b1;
      ab_le <= 1'b1;
      a_drv <= d;
      cyc(8);
      pr(2'd1, {14'h0, d});
      rnd(d);
      a_drv  <= d;
      ab_clk <= 1'b0;
      cyc(8);
      pr(2'd1, {14'h0, d});
      rd(STAT_ADDR, 32'h0000_002A);
      done("transparent");
      ab_clk <= 1'b1;
      cyc(8);
      ab_le <= 1'b0;
      cyc(8);
      rnd(e);
      a_drv <= e;
      cyc(8);
      pr(2'd1, {14'h0, d});
      rd(HELD_ADDR, {14'h0, d});
      done("latched");
      ab_clk <= 1'b0;
      cyc(8);
      ab_clk <= 1'b1;
      cyc(8);
      pr(2'd1, {14'h0, e});
      rd(HELD_ADDR, {14'h0, e});
      ab_oe <= 1'b0;
      cyc(8);
      pr(2'd1, {13'h0, 1'b1, e});
      done("clocked");
      rnd(d);
      b_drv   <= d;
      ba_le   <= 1'b1;
      ba_oe_n <= 1'b0;
      cyc(8);
      pr(2'd2, {14'h0, d});
      rd(STAT_ADDR, 32'h0000_0052);
      ba_oe_n <= 1'b1;
      ba_le   <= 1'b0;
      cyc(8);
      pr(2'd2, {13'h0, 1'b1, d});
      done("b_to_a");
      bus(1'b1, CTRL_ADDR, 32'h1);
      ab_oe <= 1'b1;
      for (i = 0; i < 18; i++) begin
         rnd(log_w[i]);
         ab_clk <= 1'b0;
         a_drv  <= log_w[i];
         cyc(4);
         ab_clk <= 1'b1;
         cyc(4);
      end
      cyc(8);
      rd(STAT_ADDR, 32'h0000_1025);
      rd(CTRL_ADDR, 32'h1);
      for (i = 0; i < 17; i++) rd(LOG_ADDR, {14'h0, log_w[i]});
      rd(LOG_ADDR, 32'h0);
      rd(STAT_ADDR, 32'h0000_0023);
      bus(1'b1, STAT_ADDR, 32'h1);
      rd(STAT_ADDR, 32'h0000_0022);
      done("log");
      conclude();
   end
endmodule : bidir_latch_register_transceiver_test
